// file: common/sccr_defs.vh
// constants for the system clock control register block
// assumes a word-addressed register port, byte offsets with 32-bit data
`ifndef SCCR_DEFS_VH
`define SCCR_DEFS_VH

`define SCCR_ADDR_W          8
`define SCCR_OFS_SYSCTL      8'h00
`define SCCR_RESET_VAL       32'h0001_0000
// writable bits: 23, 20, 17-16, 13-12, 10-8, 2-0
`define SCCR_WR_MASK         32'h0093_3707
`define SCCR_BIT_ADC_STOP    20
`define SCCR_BIT_RSVD23      23
`define SCCR_COSEL_HI        17
`define SCCR_COSEL_LO        16
`define SCCR_BIT_TSRC        13
`define SCCR_BIT_PSRC        12
`define SCCR_PRE_HI          10
`define SCCR_PRE_LO          8
`define SCCR_GEAR_HI         2
`define SCCR_GEAR_LO         0
`define SCCR_COSEL_LOW_OSC   2'h0
`define SCCR_COSEL_SYS_HALF  2'h1
`define SCCR_COSEL_SYS       2'h2
`define SCCR_COSEL_TIMER     2'h3
`define SCCR_GEAR_DIV1       3'h0
`define SCCR_GEAR_DIV2       3'h4
`define SCCR_GEAR_DIV4       3'h5
`define SCCR_GEAR_DIV8       3'h6

`endif

// file: src/sccr_top.v
// system clock control register and the clock selection it steers
// assumes the fast source clock is sampled as a level in clk_sys; divided clocks are
// produced as enable-free toggled levels, so fast sources must be slower than clk_sys/2
// reserved gear and prescaler codes behave as divide by one
//
// Summary of operation
// - a one in the converter stop bit gates off the converter clock, a zero lets it run.
// - after reset the converter stop bit reads zero so the converter clock runs.
// - the output select field picks low-speed, half system, system or timer source clock.
// - bit 13 picks the timer prescale source from the peripheral base or low-speed clock.
// - bit 12 picks the peripheral base from the gear clock or the undivided fast clock.
// - the prescaler field divides the peripheral base by 1, 2, 4, 8, 16 or 32.
// - the gear field divides the fast source by 1, 2, 4 or 8.
// - the control register sits at offset zero of the controller's register space.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "sccr_defs.vh"

module sccr_top (
    input  wire                      clk_sys,
    input  wire                      rst_n,
    input  wire [`SCCR_ADDR_W-1:0]   reg_addr,
    input  wire [31:0]               reg_wdata,
    input  wire                      reg_wr,
    input  wire                      reg_rd,
    output reg  [31:0]               reg_rdata,
    input  wire                      high_speed_source_clock,
    input  wire                      low_speed_osc_clock,
    input  wire                      adc_clock_in,
    output wire                      adc_clock_out,
    output wire                      clock_output_pin,
    output wire                      peripheral_prescaled_clock,
    output wire                      timer_prescale_source,
    output wire [31:0]               system_clock_control
);

    // ----------------------------------------------------------------
    // register fields
    // ----------------------------------------------------------------
    localparam [31:0] RST_WORD = `SCCR_RESET_VAL;

    // strobe qualified by the one mapped offset; reads and writes share it
    function reg_hit;
        input                    strobe;
        input [`SCCR_ADDR_W-1:0] addr;
        begin
            reg_hit = strobe && (addr == `SCCR_OFS_SYSCTL);
        end
    endfunction

    // fields are held apart, so unused positions have no storage at all
    reg         adc_stop_ff;
    reg         rsvd23_ff;
    reg  [1:0]  cosel_ff;
    reg         tsrc_ff;
    reg         psrc_ff;
    reg  [2:0]  pre_ff;
    reg  [2:0]  gear_ff;
    reg  [31:0] nxt_rdata;
    wire        nxt_adc_stop;
    wire        nxt_rsvd23;
    wire [1:0]  nxt_cosel;
    wire        nxt_tsrc;
    wire        nxt_psrc;
    wire [2:0]  nxt_pre;
    wire [2:0]  nxt_gear;
    wire [31:0] wr_word;
    wire [31:0] ctl_word;
    wire        wr_hit;
    wire        rd_hit;

    assign wr_hit  = reg_hit(reg_wr, reg_addr);
    assign rd_hit  = reg_hit(reg_rd, reg_addr);
    assign wr_word = reg_wdata & `SCCR_WR_MASK;

    assign nxt_adc_stop = wr_hit ? wr_word[`SCCR_BIT_ADC_STOP] : adc_stop_ff;
    assign nxt_rsvd23   = wr_hit ? wr_word[`SCCR_BIT_RSVD23] : rsvd23_ff;
    assign nxt_cosel    = wr_hit ? wr_word[`SCCR_COSEL_HI:`SCCR_COSEL_LO] : cosel_ff;
    assign nxt_tsrc     = wr_hit ? wr_word[`SCCR_BIT_TSRC] : tsrc_ff;
    assign nxt_psrc     = wr_hit ? wr_word[`SCCR_BIT_PSRC] : psrc_ff;
    assign nxt_pre      = wr_hit ? wr_word[`SCCR_PRE_HI:`SCCR_PRE_LO] : pre_ff;
    assign nxt_gear     = wr_hit ? wr_word[`SCCR_GEAR_HI:`SCCR_GEAR_LO] : gear_ff;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            adc_stop_ff <= RST_WORD[`SCCR_BIT_ADC_STOP];
            rsvd23_ff   <= RST_WORD[`SCCR_BIT_RSVD23];
            cosel_ff    <= RST_WORD[`SCCR_COSEL_HI:`SCCR_COSEL_LO];
            tsrc_ff     <= RST_WORD[`SCCR_BIT_TSRC];
            psrc_ff     <= RST_WORD[`SCCR_BIT_PSRC];
            pre_ff      <= RST_WORD[`SCCR_PRE_HI:`SCCR_PRE_LO];
            gear_ff     <= RST_WORD[`SCCR_GEAR_HI:`SCCR_GEAR_LO];
        end else begin
            adc_stop_ff <= nxt_adc_stop;
            rsvd23_ff   <= nxt_rsvd23;
            cosel_ff    <= nxt_cosel;
            tsrc_ff     <= nxt_tsrc;
            psrc_ff     <= nxt_psrc;
            pre_ff      <= nxt_pre;
            gear_ff     <= nxt_gear;
        end
    end

    // unused positions are constant zero, whatever was written there
    assign ctl_word = {8'h00, rsvd23_ff, 2'h0, adc_stop_ff, 2'h0, cosel_ff,
                       2'h0, tsrc_ff, psrc_ff, 1'b0, pre_ff, 5'h00, gear_ff};

    // unmapped reads return zero; data only in the cycle after the strobe
    always @* begin
        if (rd_hit) begin
            nxt_rdata = ctl_word;
        end else begin
            nxt_rdata = 32'h0000_0000;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= nxt_rdata;
        end
    end

    assign system_clock_control = ctl_word;

    // ----------------------------------------------------------------
    // divider chains
    // ----------------------------------------------------------------
    // binary counters clocked in clk_sys on the source's rising edge
    function [5:0] div_step;
        input       src_rise;
        input [5:0] cnt;
        begin
            div_step = src_rise ? cnt + 6'h01 : cnt;
        end
    endfunction

    reg  [5:0] fc_cnt_ff;
    reg  [5:0] per_cnt_ff;
    reg  [1:0] sys_cnt_ff;
    reg        fc_dly_ff;
    reg        per_dly_ff;
    wire [5:0] nxt_fc_cnt;
    wire [5:0] nxt_per_cnt;
    wire [1:0] nxt_sys_cnt;
    reg        gear_clk;
    reg        pre_clk;
    wire       periph_base;
    wire [2:0] gear_code;
    wire [2:0] pre_code;

    assign gear_code = gear_ff;
    assign pre_code  = pre_ff;

    // counters run freely; only the taps move with the fields, so a new ratio needs no restart
    assign nxt_fc_cnt  = div_step(high_speed_source_clock & ~fc_dly_ff, fc_cnt_ff);
    assign nxt_per_cnt = div_step(periph_base & ~per_dly_ff, per_cnt_ff);
    assign nxt_sys_cnt = sys_cnt_ff + 2'h1;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            fc_cnt_ff  <= 6'h00;
            per_cnt_ff <= 6'h00;
            sys_cnt_ff <= 2'h0;
            fc_dly_ff  <= 1'b0;
            per_dly_ff <= 1'b0;
        end else begin
            fc_dly_ff  <= high_speed_source_clock;
            per_dly_ff <= periph_base;
            fc_cnt_ff  <= nxt_fc_cnt;
            per_cnt_ff <= nxt_per_cnt;
            sys_cnt_ff <= nxt_sys_cnt;
        end
    end

    // reserved gear codes fall back to the undivided source
    always @* begin
        case (gear_code)
            `SCCR_GEAR_DIV1: gear_clk = high_speed_source_clock;
            `SCCR_GEAR_DIV2: gear_clk = fc_cnt_ff[0];
            `SCCR_GEAR_DIV4: gear_clk = fc_cnt_ff[1];
            `SCCR_GEAR_DIV8: gear_clk = fc_cnt_ff[2];
            default:         gear_clk = high_speed_source_clock;
        endcase
    end

    assign periph_base = psrc_ff ? high_speed_source_clock : gear_clk;

    // reserved prescaler codes give the undivided base
    always @* begin
        case (pre_code)
            3'h0:    pre_clk = periph_base;
            3'h1:    pre_clk = per_cnt_ff[0];
            3'h2:    pre_clk = per_cnt_ff[1];
            3'h3:    pre_clk = per_cnt_ff[2];
            3'h4:    pre_clk = per_cnt_ff[3];
            3'h5:    pre_clk = per_cnt_ff[4];
            default: pre_clk = periph_base;
        endcase
    end

    assign peripheral_prescaled_clock = pre_clk;
    assign timer_prescale_source = tsrc_ff ? low_speed_osc_clock : periph_base;

    // ----------------------------------------------------------------
    // clock output and converter gate
    // ----------------------------------------------------------------
    reg cout_sel;
    always @* begin
        case (cosel_ff)
            `SCCR_COSEL_LOW_OSC:  cout_sel = low_speed_osc_clock;
            `SCCR_COSEL_SYS_HALF: cout_sel = sys_cnt_ff[0];
            `SCCR_COSEL_SYS:      cout_sel = clk_sys;
            `SCCR_COSEL_TIMER:    cout_sel = timer_prescale_source;
            default:              cout_sel = low_speed_osc_clock;
        endcase
    end
    assign clock_output_pin = cout_sel;

    // simple and-gate; software must idle the converter first, so glitches are harmless
    assign adc_clock_out = adc_clock_in & ~adc_stop_ff;

endmodule // sccr_top

// file: verification/sccr_top_props.sv
// checker for the system clock control register block
// assumes it is bound to sccr_top and sees only its ports
`timescale 1ns/1ps
`include "sccr_defs.vh"
module sccr_top_props (
    input wire clk_sys, rst_n, reg_wr, reg_rd, high_speed_source_clock,
    input wire low_speed_osc_clock, adc_clock_in, adc_clock_out, clock_output_pin,
    input wire peripheral_prescaled_clock, timer_prescale_source,
    input wire [`SCCR_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata, reg_rdata, system_clock_control
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_hit; reg_addr == 8'h00; endsequence
    sequence s_half;
        system_clock_control[17:16] == 2'h1 ##1 system_clock_control[17:16] == 2'h1;
    endsequence
    AST_COS1: assert property (s_half |-> clock_output_pin != $past(clock_output_pin))
        else $error("output not half system clock");
    AST_PSRC: assert property (!system_clock_control[13] && system_clock_control[12] |->
        timer_prescale_source == high_speed_source_clock) else $error("base not fast clock");
    AST_RST: assert property ($rose(rst_n) |-> system_clock_control == `SCCR_RESET_VAL)
        else $error("bad reset value");
    AST_WR: assert property (reg_wr && reg_addr == 8'h00 |=>
        system_clock_control == ($past(reg_wdata) & `SCCR_WR_MASK)) else $error("bad write");
    AST_UNW: assert property (reg_wr && reg_addr != 8'h00 |=> $stable(system_clock_control))
        else $error("unmapped write landed");
    AST_RD: assert property (reg_rd ##0 s_hit |=> reg_rdata == $past(system_clock_control))
        else $error("bad read data");
    AST_RDZ: assert property (!reg_rd || reg_addr != 8'h00 |=> reg_rdata == 32'h0)
        else $error("read data not zero");
    AST_MASK: assert property ((system_clock_control & ~`SCCR_WR_MASK) == 32'h0)
        else $error("unused bit set");
    AST_ADC: assert property (adc_clock_out == (adc_clock_in && !system_clock_control[20]))
        else $error("converter gate wrong");
    AST_COS0: assert property (system_clock_control[17:16] == 2'h0 |->
        clock_output_pin == low_speed_osc_clock) else $error("output not low-speed");
    AST_COS3: assert property (system_clock_control[17:16] == 2'h3 |->
        clock_output_pin == timer_prescale_source) else $error("output not timer source");
    AST_TSRC: assert property (system_clock_control[13] |->
        timer_prescale_source == low_speed_osc_clock) else $error("timer source wrong");
endmodule // sccr_top_props

// file: verification/sccr_top_tb.sv
// bench for the system clock control register block
// assumes sccr_top and the checker are compiled first
`timescale 1ns/1ps
`include "sccr_defs.vh"
module system_clock_select_register_tb;
    logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, adc = 0, adc_run = 1;
    logic [7:0] reg_addr = 8'h00, a;
    logic [31:0] reg_wdata = 32'h0, d, m;
    logic [3:0] cyc = 4'h0;
    logic [4:0] prv = 5'h0;
    wire [31:0] reg_rdata, scc;
    wire adc_o, cop, ppc, tps;
    wire [4:0] sig = {cop, tps, ppc, cyc[3], cyc[1]};
    int miscompares = 0, total_checks = 0, n[5];
    sccr_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_clock_in(adc),
        .high_speed_source_clock(cyc[1]), .low_speed_osc_clock(cyc[3]), .adc_clock_out(adc_o),
        .clock_output_pin(cop), .peripheral_prescaled_clock(ppc), .timer_prescale_source(tps),
        .system_clock_control(scc));
    initial forever #10 clk_sys = ~clk_sys;
    // edge counters: index 0 fast, 1 slow, 2 prescaled, 3 timer, 4 output pin
    always @(posedge clk_sys) begin
        cyc <= cyc + 4'h1;
        adc <= adc_run ? 1'($urandom) : 1'b0;
        prv <= sig;
        for (int j = 0; j < 5; j++) if (sig[j] && !prv[j]) n[j]++;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] v);
        @(posedge clk_sys) begin reg_addr <= ad; reg_wdata <= v; reg_wr <= 1'b1; end
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] ad);
        @(posedge clk_sys) begin reg_addr <= ad; reg_rd <= 1'b1; end
        @(posedge clk_sys) reg_rd <= 1'b0;
        @(negedge clk_sys) d = reg_rdata;
    endtask
    // phase of the dividers is unknown, so allow two output periods of slack
    function automatic logic near(int c, int r, int dv);
        return c * dv >= r - 2 * dv && c * dv <= r + 2 * dv;
    endfunction
    task meas(input logic [31:0] v);
        wr(8'h00, v);
        repeat (40) @(posedge clk_sys);
        @(negedge clk_sys) n = '{5{0}};
        repeat (1024) @(negedge clk_sys);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin #1ms; miscompares++; end_sim; end
    initial begin
        void'($urandom(47564));
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h00); chk(d, `SCCR_RESET_VAL);
        m = `SCCR_RESET_VAL;
        for (int i = 0; i < 24; i++) begin
            a = (i % 4 == 1) ? 8'($urandom_range(255, 1)) : 8'h00;
            d = $urandom & 32'hff7f_fbff;
            d[2:0] = d[2] ? {2'b10, d[0]} : 3'h0;
            wr(a, d);
            if (a == 8'h00) m = d & `SCCR_WR_MASK;
            rd(a); chk(d, a == 8'h00 ? m : 32'h0);
            chk(scc, m);
        end
        for (int k = 0; k < 6; k++) begin
            meas(32'h0000_1000 | (32'(k) << 8)); chk(near(n[2], n[0], 1 << k), 1'b1);
        end
        for (int g = 0; g < 4; g++) begin
            meas(g == 0 ? 32'h0 : 32'(g + 3)); chk(near(n[3], n[0], 1 << g), 1'b1);
        end
        meas(32'h0000_2000); chk(near(n[3], n[1], 1), 1'b1);
        meas(32'h0001_0000); chk(near(n[4], 1024, 2), 1'b1);
        meas(32'h0002_0000);
        @(posedge clk_sys) #1 chk(cop, 1'b1);
        @(negedge clk_sys) #1 chk(cop, 1'b0);
        meas(32'h0003_1000); chk(near(n[4], n[0], 1), 1'b1);
        // conversion halted before the stop bit goes up, then the source runs again
        adc_run = 1'b0;
        meas(32'h0010_0000);
        adc_run = 1'b1;
        repeat (8) @(negedge clk_sys) chk(adc_o, 1'b0);
        @(posedge clk_sys) rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h00); chk(d, `SCCR_RESET_VAL);
        repeat (8) @(negedge clk_sys) chk(adc_o, adc);
        end_sim;
    end
endmodule // system_clock_select_register_tb
bind sccr_top sccr_top_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .high_speed_source_clock(high_speed_source_clock),
    .low_speed_osc_clock(low_speed_osc_clock), .adc_clock_in(adc_clock_in),
    .adc_clock_out(adc_clock_out), .clock_output_pin(clock_output_pin),
    .peripheral_prescaled_clock(peripheral_prescaled_clock), .reg_addr(reg_addr),
    .timer_prescale_source(timer_prescale_source), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .system_clock_control(system_clock_control));
